// [common/pps_pkg.sv]
// package for the per-port phy status, crossover and event register bank
// assumes a 16-bit register space with the port number in address bits 15:12
package pps_pkg;
    localparam int NUM_PORTS = 5;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int EVT_W = 8;
    localparam int LVL_W = 7;

    // register offsets inside one port region (low twelve address bits)
    localparam logic [11:0] OFF_LINK_STATE = 12'h126;
    localparam logic [11:0] OFF_SYMERR_COUNT = 12'h12a;
    localparam logic [11:0] OFF_EVENT_EN_STS = 12'h136;
    localparam logic [11:0] OFF_XOVER_CTRL = 12'h138;
    localparam logic [11:0] OFF_MISC_CTRL_STS = 12'h13e;
    // first port region number; port n sits at nibble FIRST_PORT + n
    localparam logic [3:0] FIRST_PORT = 4'h1;

    // summary interrupt registers in region 0
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0000;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0004;

    // pcs_link_state fields
    localparam int LINK_100_BIT = 0;
    localparam int LINK_1000_BIT = 1;

    // event latch positions, enables sit EVT_EN_SHIFT above
    localparam int EVT_LINK_UP = 0;
    localparam int EVT_REMOTE_FAULT = 1;
    localparam int EVT_LINK_DOWN = 2;
    localparam int EVT_LP_ACK = 3;
    localparam int EVT_PD_FAULT = 4;
    localparam int EVT_PAGE_RX = 5;
    localparam int EVT_RX_ERROR = 6;
    localparam int EVT_JABBER = 7;
    localparam int EVT_EN_SHIFT = 8;

    // crossover_control fields
    localparam int XOVER_AUTO_OFF_BIT = 6;
    localparam int XOVER_FIXED_SEL_BIT = 7;

    // phy_misc_control_status fields
    localparam int MISC_JABBER_EN_BIT = 9;
    localparam int MISC_SPEED_1000_BIT = 6;
    localparam int MISC_SPEED_100_BIT = 5;
    localparam int MISC_SPEED_10_BIT = 4;
    localparam int MISC_DUPLEX_BIT = 3;
    localparam int MISC_MASTER_BIT = 2;
    localparam logic [15:0] MISC_RW_MASK = 16'hf380;

    // reset values
    localparam logic [15:0] RST_SYMERR = 16'h0000;
    localparam logic [7:0] RST_EVENTS = 8'h00;
    localparam logic [7:0] RST_EVENT_EN = 8'h00;
    localparam logic [15:0] RST_XOVER = 16'h0000;
    localparam logic [15:0] RST_MISC = 16'h0300;
    localparam logic [4:0] RST_IRQ_STATUS = 5'h00;
    localparam logic [4:0] RST_IRQ_MASK = 5'h00;
    localparam logic [15:0] SYMERR_MAX = 16'hffff;
endpackage

// [design/pps_regs.sv]
// register bank for the five copper phy ports: link state, symbol error
// counter, event latches with enables, crossover control and resolved status
// assumes phy event pulses come from logic on clk; phy status levels may come
// from any domain and are resynchronised here
// register space: port n (1..5) sits in address nibble n, and two summary
// registers sit in region 0; a read answers one cycle later and never stalls
// event inputs are one-cycle pulses; a level held high sets its latch again
// on every cycle, so a read only sticks once the event source is quiet
// every output comes straight from a flop; decode and muxing stay in named
// wires so that each flop block holds a single register
// the summary status is sticky per port and set wins over a same-cycle clear,
// so a port still requesting cannot be cleared until its latches are read
// status levels lag their pins by two cycles through the resynchroniser
module pps_regs
    import pps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [pps_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pps_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pps_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pps_pkg::NUM_PORTS-1:0] link_1000_up,
    input wire logic [pps_pkg::NUM_PORTS-1:0] link_100_up,
    input wire logic [pps_pkg::NUM_PORTS-1:0] speed_1000,
    input wire logic [pps_pkg::NUM_PORTS-1:0] speed_100,
    input wire logic [pps_pkg::NUM_PORTS-1:0] speed_10,
    input wire logic [pps_pkg::NUM_PORTS-1:0] duplex_full,
    input wire logic [pps_pkg::NUM_PORTS-1:0] role_master,
    input wire logic [pps_pkg::NUM_PORTS-1:0] jabber_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] rx_error_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] page_rx_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] pd_fault_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] lp_ack_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] remote_fault_evt,
    input wire logic [pps_pkg::NUM_PORTS-1:0] symbol_error_frame,
    output logic [pps_pkg::NUM_PORTS-1:0] port_irq,
    output logic [pps_pkg::NUM_PORTS-1:0] jabber_count_en,
    output logic [pps_pkg::NUM_PORTS-1:0] xover_auto,
    output logic [pps_pkg::NUM_PORTS-1:0] xover_force_mdi,
    output logic [pps_pkg::NUM_PORTS-1:0] xover_force_mdix,
    output logic irq
);
    import pps_pkg::*;

    // per-port read views and requests gathered for the shared logic
    logic [DATA_W-1:0] port_rdata [NUM_PORTS];
    logic [NUM_PORTS-1:0] port_hit;
    logic [NUM_PORTS-1:0] port_irq_d;
    logic [NUM_PORTS-1:0] port_irq_q;

    // registered crossover and jabber outputs, one bit per port
    logic [NUM_PORTS-1:0] xover_auto_q;
    logic [NUM_PORTS-1:0] force_mdi_q;
    logic [NUM_PORTS-1:0] force_mdix_q;
    logic [NUM_PORTS-1:0] jabber_en_q;

    // summary interrupt state and the bus answer
    logic [4:0] irq_status_q;
    logic [4:0] irq_status_d;
    logic [4:0] irq_mask_q;
    logic [4:0] irq_mask_d;
    logic irq_q;
    logic irq_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // summary register decode
    wire hit_irq_status = (reg_addr == ADDR_IRQ_STATUS);
    wire hit_irq_mask = (reg_addr == ADDR_IRQ_MASK);
    wire wr_irq_status = reg_wr && hit_irq_status;
    wire wr_irq_mask = reg_wr && hit_irq_mask;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // port p answers in address nibble FIRST_PORT + p
            localparam logic [3:0] PORT_NIB = FIRST_PORT + 4'(p);

            logic [LVL_W-1:0] lvl_meta_q;
            logic [LVL_W-1:0] lvl_q;
            logic link_any_q;
            logic [EVT_W-1:0] evt_q;
            logic [EVT_W-1:0] evt_d;
            logic [EVT_W-1:0] en_q;
            logic [EVT_W-1:0] en_d;
            logic [DATA_W-1:0] cnt_q;
            logic [DATA_W-1:0] cnt_d;
            logic [DATA_W-1:0] xover_q;
            logic [DATA_W-1:0] xover_d;
            logic [DATA_W-1:0] misc_q;
            logic [DATA_W-1:0] misc_d;

            // region decode: each port answers only in its own nibble
            wire in_region = (reg_addr[15:12] == PORT_NIB);
            wire hit_link = in_region && (reg_addr[11:0] == OFF_LINK_STATE);
            wire hit_cnt = in_region && (reg_addr[11:0] == OFF_SYMERR_COUNT);
            wire hit_evt = in_region && (reg_addr[11:0] == OFF_EVENT_EN_STS);
            wire hit_xover = in_region && (reg_addr[11:0] == OFF_XOVER_CTRL);
            wire hit_misc = in_region && (reg_addr[11:0] == OFF_MISC_CTRL_STS);
            wire rd_cnt = reg_rd && hit_cnt;
            wire rd_evt = reg_rd && hit_evt;

            // write strobes per stored register
            wire wr_evt = reg_wr && hit_evt;
            wire wr_xover = reg_wr && hit_xover;
            wire wr_misc = reg_wr && hit_misc;

            // raw status levels, resynchronised below
            wire [LVL_W-1:0] lvl_raw = {link_1000_up[p], link_100_up[p], speed_1000[p], speed_100[p],
                                        speed_10[p], duplex_full[p], role_master[p]};
            wire s_link_1000 = lvl_q[6];
            wire s_link_100 = lvl_q[5];
            wire link_any = s_link_1000 || s_link_100;
            wire link_up_evt = link_any && !link_any_q;
            wire link_down_evt = !link_any && link_any_q;

            // jabber events only count while the jabber counter is enabled
            wire [EVT_W-1:0] evt_in;
            assign evt_in[EVT_JABBER] = jabber_evt[p] && misc_q[MISC_JABBER_EN_BIT];
            assign evt_in[EVT_RX_ERROR] = rx_error_evt[p];
            assign evt_in[EVT_PAGE_RX] = page_rx_evt[p];
            assign evt_in[EVT_PD_FAULT] = pd_fault_evt[p];
            assign evt_in[EVT_LP_ACK] = lp_ack_evt[p];
            assign evt_in[EVT_LINK_DOWN] = link_down_evt;
            assign evt_in[EVT_REMOTE_FAULT] = remote_fault_evt[p];
            assign evt_in[EVT_LINK_UP] = link_up_evt;

            // read clears, but a new event in the same cycle still lands
            assign evt_d = (rd_evt ? RST_EVENTS : evt_q) | evt_in;
            assign en_d = wr_evt ? reg_wdata[15:8] : en_q;

            // counter saturates rather than wrapping to a misleading small value
            wire cnt_at_max = (cnt_q == SYMERR_MAX);
            wire cnt_inc = symbol_error_frame[p] && (rd_cnt || !cnt_at_max);
            wire [DATA_W-1:0] cnt_base = rd_cnt ? RST_SYMERR : cnt_q;
            assign cnt_d = cnt_base + DATA_W'(cnt_inc);

            assign xover_d = wr_xover ? reg_wdata : xover_q;
            assign misc_d = wr_misc ? (reg_wdata & MISC_RW_MASK) : misc_q;

            // live read-only status bits merged with stored control bits
            wire [DATA_W-1:0] misc_view;
            assign misc_view[15:7] = misc_q[15:7];
            assign misc_view[MISC_SPEED_1000_BIT] = lvl_q[4];
            assign misc_view[MISC_SPEED_100_BIT] = lvl_q[3];
            assign misc_view[MISC_SPEED_10_BIT] = lvl_q[2];
            assign misc_view[MISC_DUPLEX_BIT] = lvl_q[1];
            assign misc_view[MISC_MASTER_BIT] = lvl_q[0];
            assign misc_view[1:0] = 2'h0;

            // link state view: reserved bits read zero, nothing is latched
            wire [DATA_W-1:0] link_view;
            assign link_view[15:2] = 14'h0000;
            assign link_view[LINK_1000_BIT] = s_link_1000;
            assign link_view[LINK_100_BIT] = s_link_100;

            // read data selection for this port
            assign port_hit[p] = hit_link || hit_cnt || hit_evt || hit_xover || hit_misc;
            assign port_rdata[p] = hit_link ? link_view :
                                   hit_cnt ? cnt_q :
                                   hit_evt ? {en_q, evt_q} :
                                   hit_xover ? xover_q :
                                   hit_misc ? misc_view : 16'h0000;
            assign port_irq_d[p] = |(evt_d & en_d);

            // first resynchroniser stage; only the second stage reads it
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lvl_meta_q <= '0;
                end else if (ce) begin
                    lvl_meta_q <= lvl_raw;
                end
            end

            // second stage, the only copy that views and edge detect use
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lvl_q <= '0;
                end else if (ce) begin
                    lvl_q <= lvl_meta_q;
                end
            end

            // delayed link level; resets low like a down link, so no false up event
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    link_any_q <= 1'h0;
                end else if (ce) begin
                    link_any_q <= link_any;
                end
            end

            // event latches; read clear and new events merge in evt_d
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    evt_q <= RST_EVENTS;
                end else if (ce) begin
                    evt_q <= evt_d;
                end
            end

            // interrupt enables
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_q <= RST_EVENT_EN;
                end else if (ce) begin
                    en_q <= en_d;
                end
            end

            // symbol error frame counter
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q <= RST_SYMERR;
                end else if (ce) begin
                    cnt_q <= cnt_d;
                end
            end

            // stored crossover register, every bit reads back as written
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    xover_q <= RST_XOVER;
                end else if (ce) begin
                    xover_q <= xover_d;
                end
            end

            // stored control bits; read-only positions stay zero here
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    misc_q <= RST_MISC;
                end else if (ce) begin
                    misc_q <= misc_d;
                end
            end

            // automatic crossover runs unless the auto-off bit is set
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    xover_auto_q[p] <= !RST_XOVER[XOVER_AUTO_OFF_BIT];
                end else if (ce) begin
                    xover_auto_q[p] <= !xover_d[XOVER_AUTO_OFF_BIT];
                end
            end

            // straight wiring only with auto off, so the select bit is dead otherwise
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    force_mdi_q[p] <= RST_XOVER[XOVER_AUTO_OFF_BIT] && RST_XOVER[XOVER_FIXED_SEL_BIT];
                end else if (ce) begin
                    force_mdi_q[p] <= xover_d[XOVER_AUTO_OFF_BIT] && xover_d[XOVER_FIXED_SEL_BIT];
                end
            end

            // crossed wiring only with auto off
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    force_mdix_q[p] <= RST_XOVER[XOVER_AUTO_OFF_BIT] && !RST_XOVER[XOVER_FIXED_SEL_BIT];
                end else if (ce) begin
                    force_mdix_q[p] <= xover_d[XOVER_AUTO_OFF_BIT] && !xover_d[XOVER_FIXED_SEL_BIT];
                end
            end

            // jabber counter enable, a flop copy of its control bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    jabber_en_q[p] <= RST_MISC[MISC_JABBER_EN_BIT];
                end else if (ce) begin
                    jabber_en_q[p] <= misc_d[MISC_JABBER_EN_BIT];
                end
            end

            // port request moves in the same edge as its latches and enables
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    port_irq_q[p] <= 1'h0;
                end else if (ce) begin
                    port_irq_q[p] <= port_irq_d[p];
                end
            end
        end
    endgenerate

    // summary status: a port raising its request sets a sticky bit, write one clears
    // the set term is applied after the clear so a same-cycle request is kept
    wire [4:0] status_clr = wr_irq_status ? reg_wdata[4:0] : 5'h00;
    assign irq_status_d = (irq_status_q & ~status_clr) | port_irq_d;

    // next mask and summary interrupt, so irq moves in the same edge as both
    assign irq_mask_d = wr_irq_mask ? reg_wdata[4:0] : irq_mask_q;
    assign irq_d = |(irq_status_d & irq_mask_d);

    // read mux; port hits are exclusive so an or-reduction is enough
    always_comb begin
        rdata_d = 16'h0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            rdata_d = rdata_d | (port_hit[i] ? port_rdata[i] : 16'h0000);
        end
        if (hit_irq_status) begin
            rdata_d = {11'h000, irq_status_q};
        end else if (hit_irq_mask) begin
            rdata_d = {11'h000, irq_mask_q};
        end
    end

    // bus answer: only a taken read moves it, so it stands until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (ce && reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // summary status, sticky per port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_q <= RST_IRQ_STATUS;
        end else if (ce) begin
            irq_status_q <= irq_status_d;
        end
    end

    // summary mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= RST_IRQ_MASK;
        end else if (ce) begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // summary interrupt level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'h0;
        end else if (ce) begin
            irq_q <= irq_d;
        end
    end

    // outputs taken straight from flops
    assign reg_rdata = rdata_q;
    assign port_irq = port_irq_q;
    assign jabber_count_en = jabber_en_q;
    assign xover_auto = xover_auto_q;
    assign xover_force_mdi = force_mdi_q;
    assign xover_force_mdix = force_mdix_q;
    assign irq = irq_q;
endmodule

// [sim/pps_regs_monitor.sv]
// checker for the per-port register bank: read answers, crossover, jabber and irq outputs
// assumes it is bound to pps_regs and sees only that module's ports
module pps_regs_monitor
    import pps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [pps_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pps_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pps_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [pps_pkg::NUM_PORTS-1:0] port_irq,
    input wire logic [pps_pkg::NUM_PORTS-1:0] jabber_count_en,
    input wire logic [pps_pkg::NUM_PORTS-1:0] xover_auto,
    input wire logic [pps_pkg::NUM_PORTS-1:0] xover_force_mdi,
    input wire logic [pps_pkg::NUM_PORTS-1:0] xover_force_mdix,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decoded accesses; port 2 crossover and port 1 control are the ones the bench drives hardest
    wire wr_xover = ce && reg_wr && (reg_addr == 16'h2138);
    wire rd_xover = ce && reg_rd && (reg_addr == 16'h2138);
    wire wr_misc = ce && reg_wr && (reg_addr == 16'h113e);
    wire rd_misc = ce && reg_rd && (reg_addr == 16'h113e);
    wire wr_evt_en = ce && reg_wr && (reg_addr == 16'h1136);
    wire wr_mask = ce && reg_wr && (reg_addr == 16'h0004);
    wire rd_unmapped = ce && reg_rd && (reg_addr[15:12] > 4'h5);

    chk_auto_off_write: assert property (wr_xover |=> xover_auto[1] == !$past(reg_wdata[6]))
        else $error("crossover auto output did not follow the written bit");
    chk_force_mdi_write: assert property (wr_xover |=> xover_force_mdi[1] == ($past(reg_wdata[6]) && $past(reg_wdata[7])))
        else $error("forced straight wiring output wrong after write");
    chk_force_exclusive: assert property (((xover_force_mdi | xover_force_mdix) & xover_auto) == 5'h00 && (xover_force_mdi & xover_force_mdix) == 5'h00)
        else $error("fixed wiring forced while automatic crossover runs");
    chk_xover_readback: assert property (rd_xover |=> reg_rdata[6] == !xover_auto[1])
        else $error("crossover read value disagrees with auto output");
    chk_jabber_en_write: assert property (wr_misc |=> jabber_count_en[0] == $past(reg_wdata[9]))
        else $error("jabber counter enable did not follow write");
    chk_misc_read_jabber: assert property (rd_misc |=> reg_rdata[9] == jabber_count_en[0])
        else $error("control read disagrees with jabber enable output");
    chk_unmapped_zero: assert property (rd_unmapped |=> reg_rdata == 16'h0000)
        else $error("unmapped region read returned nonzero");
    chk_rdata_holds: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_no_enable_quiet: assert property (wr_evt_en && reg_wdata[15:8] == 8'h00 |=> port_irq[0] == 1'b0)
        else $error("port request high with all enables clear");
    chk_mask_quiet: assert property (wr_mask && reg_wdata[4:0] == 5'h00 |=> !irq)
        else $error("irq high with the summary mask clear");

    // main scenarios seen
    cover property (wr_xover && reg_wdata[6]);
    cover property ($rose(irq));
    cover property (rd_unmapped);
endmodule

bind pps_regs pps_regs_monitor u_pps_mon (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_irq, .jabber_count_en, .xover_auto, .xover_force_mdi, .xover_force_mdix, .irq);

// [sim/pps_regs_tb_top.sv]
// self-checking bench for pps_regs: register table, event latches, irq, counter, crossover, reset
// assumes one 200 MHz clock; the bench drives every design input itself
module pps_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic wr; logic [15:0] addr; logic [15:0] val;} pps_row_type;
    logic clk, rst_n, ce, reg_wr, reg_rd, irq;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] link_1000_up, link_100_up, speed_1000, speed_100, speed_10, duplex_full, role_master;
    logic [4:0] jabber_evt, rx_error_evt, page_rx_evt, pd_fault_evt, lp_ack_evt, remote_fault_evt, symbol_error_frame;
    logic [4:0] port_irq, jabber_count_en, xover_auto, xover_force_mdi, xover_force_mdix;
    int fail_count = 0;
    int checks = 0;
    int epos [6] = '{7, 6, 5, 4, 3, 1};
    // reads compare, writes set up the next read; status inputs are fixed per port
    pps_row_type rows [24] = '{'{0, 16'h1126, 16'h0000}, '{0, 16'h112a, 16'h0000}, '{0, 16'h1136, 16'h0000},
        '{0, 16'h1138, 16'h0000}, '{0, 16'h113e, 16'h034c}, '{0, 16'h213e, 16'h0320}, '{0, 16'h313e, 16'h0310},
        '{0, 16'h413e, 16'h0308}, '{0, 16'h513e, 16'h0304}, '{0, 16'h7000, 16'h0000}, '{1, 16'h2138, 16'hffff},
        '{0, 16'h2138, 16'hffff}, '{1, 16'h113e, 16'hffff}, '{0, 16'h113e, 16'hf3cc}, '{1, 16'h1126, 16'hffff},
        '{0, 16'h1126, 16'h0000}, '{1, 16'h1136, 16'h00ff}, '{0, 16'h1136, 16'h0000}, '{1, 16'h1136, 16'ha5ff},
        '{0, 16'h1136, 16'ha500}, '{1, 16'h0004, 16'h001f}, '{0, 16'h0004, 16'h001f}, '{1, 16'h7000, 16'h1234},
        '{0, 16'h7000, 16'h0000}};

    pps_regs DUT (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_1000_up,
        .link_100_up, .speed_1000, .speed_100, .speed_10, .duplex_full, .role_master, .jabber_evt, .rx_error_evt,
        .page_rx_evt, .pd_fault_evt, .lp_ack_evt, .remote_fault_evt, .symbol_error_frame, .port_irq,
        .jabber_count_en, .xover_auto, .xover_force_mdi, .xover_force_mdix, .irq);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // the #1 lets the taking edge's updates land before anyone looks
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, reg_rdata);
    endtask

    // one-cycle pulse on port 1 events: jabber, rx error, page, pd fault, lp ack, remote fault
    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        {jabber_evt[0], rx_error_evt[0], page_rx_evt[0], pd_fault_evt[0], lp_ack_evt[0], remote_fault_evt[0]} <= v;
        @(posedge clk);
        {jabber_evt[0], rx_error_evt[0], page_rx_evt[0], pd_fault_evt[0], lp_ack_evt[0], remote_fault_evt[0]} <= 6'h00;
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        {rst_n, ce, reg_wr, reg_rd, reg_addr, reg_wdata, link_1000_up, link_100_up} = '0;
        {jabber_evt, rx_error_evt, page_rx_evt, pd_fault_evt, lp_ack_evt, remote_fault_evt, symbol_error_frame} = '0;
        {speed_1000, speed_100, speed_10, duplex_full, role_master} = {5'h01, 5'h02, 5'h04, 5'h09, 5'h11};
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].wr) bus_wr(rows[i].addr, rows[i].val);
            else bus_rd(rows[i].addr, rows[i].val);
        end
        bus_wr(16'h113e, 16'h0300);
        foreach (epos[k]) begin
            pulse(6'h20 >> k);
            bus_rd(16'h1136, 16'ha500 | (16'h0001 << epos[k]));
            bus_rd(16'h1136, 16'ha500);
        end
        bus_wr(16'h113e, 16'h0000);
        chk("jabber_count_en", 16'h0000, {15'h0, jabber_count_en[0]});
        pulse(6'h20);
        bus_rd(16'h1136, 16'ha500);
        bus_wr(16'h113e, 16'h0300);
        // link events: swapping speeds keeps the link up, so no event in between
        @(posedge clk) link_100_up[0] <= 1'b1;
        repeat (4) @(posedge clk);
        bus_rd(16'h1126, 16'h0001);
        bus_rd(16'h1136, 16'ha501);
        @(posedge clk) {link_100_up[0], link_1000_up[0]} <= 2'b01;
        repeat (4) @(posedge clk);
        bus_rd(16'h1126, 16'h0002);
        bus_rd(16'h1136, 16'ha500);
        @(posedge clk) link_1000_up[0] <= 1'b0;
        repeat (4) @(posedge clk);
        bus_rd(16'h1136, 16'ha504);
        // interrupt raised, masked and cleared
        bus_wr(16'h0000, 16'h001f);
        pulse(6'h10);
        chk("port_irq", 16'h0000, {11'h0, port_irq});
        bus_rd(16'h1136, 16'ha540);
        pulse(6'h08);
        chk("port_irq", 16'h0001, {11'h0, port_irq});
        chk("irq", 16'h0001, {15'h0, irq});
        bus_wr(16'h0004, 16'h0000);
        chk("irq", 16'h0000, {15'h0, irq});
        bus_rd(16'h0000, 16'h0001);
        bus_rd(16'h1136, 16'ha520);
        chk("port_irq", 16'h0000, {11'h0, port_irq});
        bus_wr(16'h0004, 16'h001f);
        chk("irq", 16'h0001, {15'h0, irq});
        bus_wr(16'h0000, 16'h001f);
        chk("irq", 16'h0000, {15'h0, irq});
        // three back-to-back error frames on port 3
        @(posedge clk) symbol_error_frame[2] <= 1'b1;
        repeat (3) @(posedge clk);
        symbol_error_frame[2] <= 1'b0;
        bus_rd(16'h312a, 16'h0003);
        bus_rd(16'h312a, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            bus_wr(16'h2138, 16'(m << 6));
            chk("xover", {13'h0, ~m[0], m[0] & m[1], m[0] & ~m[1]}, {13'h0, xover_auto[1], xover_force_mdi[1], xover_force_mdix[1]});
        end
        // a write with the clock enable low must be ignored
        @(posedge clk) ce <= 1'b0;
        bus_wr(16'h2138, 16'h0000);
        @(posedge clk) ce <= 1'b1;
        chk("xover frozen", 16'h0002, {13'h0, xover_auto[1], xover_force_mdi[1], xover_force_mdix[1]});
        // second reset in mid-run
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("reset outs", 16'h03ff, {irq, port_irq, jabber_count_en, xover_auto});
        chk("reset force", 16'h0000, {6'h0, xover_force_mdi, xover_force_mdix});
        @(posedge clk) rst_n <= 1'b1;
        bus_rd(16'h2138, 16'h0000);
        bus_rd(16'h1136, 16'h0000);
        bus_rd(16'h113e, 16'h034c);
        wrap_up();
    end
endmodule
